/* File: rtl/oad_datapath.sv */
// Operand sizing, effective-address generation and register file.
// Assumes the decoder presents one request at a time with its extension
// words, and memory answers over the word sequencer on the same clock.
//
// Overview of operation
// - Decimal digit, byte, word and long-word operands are all handled.
// - Indirect modes: plain, postincrement, predecrement, displacement, index.
// - Increment and decrement step equals operand size: one, two or four.
// - Byte step on the stack pointer is two, keeping it even.
// - PC relative adds word displacement, or byte displacement plus index.
// - Index may come from any data or address register.
// - Absolute and immediate values come from the following extension words.
// - Implied operands read status, user or privileged stack, or PC directly.
// - Data registers are 32 bits; sizes use low 8, 16 or 32.
// - Byte or word writes to data registers keep the upper bits.
// - Bit zero is least significant, bit 31 most significant.
// - Address registers and stack pointers hold full 32-bit addresses.
// - Address registers refuse bytes; sources give low word or long.
// - Address register writes change all bits; words are sign-extended.
// - Memory is big endian; high byte sits at the even address.
// - Word and long accesses go only to even addresses.
// - Long words move as two words, high at n, low at n+2.
// - Two decimal digits per byte, more significant digit in upper nibble.
// - Register seven is the user or privileged stack pointer by mode.
`timescale 1ns/1ps
module oad_datapath
    import oad_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // Core state
    input wire logic supervisor,
    input wire logic [15:0] status_word,
    input wire logic [31:0] pc,
    // Operand request
    input wire logic req_valid,
    input wire oad_req_t req,
    output logic req_ready,
    // Register write port
    input wire logic wr_en,
    input wire oad_wr_t wr,
    output logic wr_reject,
    // Result
    output logic res_valid,
    output oad_res_t res,
    // Memory
    output logic mem_valid,
    output oad_mem_req_t mem_req,
    input wire logic mem_ready,
    input wire logic [15:0] mem_rdata
);

    typedef enum logic {ST_IDLE, ST_MEM} oad_ctl_state_t;
    oad_ctl_state_t state;

    // Register file, bit 0 is the least significant everywhere
    logic [31:0] data_reg [NREG];
    logic [31:0] addr_reg [NAREG];
    logic [31:0] user_stack_ptr;
    logic [31:0] privileged_stack_ptr;
    logic [31:0] aview [NREG];

    logic [31:0] effective_address;
    logic [31:0] direct;
    logic seq_done;
    logic seq_fault;
    logic [31:0] seq_rdata;

    // ----------------------------------------------------------------
    // Operand decode
    // ----------------------------------------------------------------
    wire logic [31:0] active_sp = supervisor ? privileged_stack_ptr : user_stack_ptr;
    wire logic acc = req_valid && req_ready;
    wire logic is_sp = (req.reg_num == SP_NUM);
    wire logic [31:0] base = aview[req.reg_num];
    wire logic [31:0] step = oad_step(req.size, is_sp);
    wire logic [31:0] long_disp = oad_sext16(req.ext.first);
    wire logic [31:0] short_disp = oad_sext8(req.ext.first[BYTE_MSB:0]);
    wire logic [31:0] idx_raw = req.index.is_addr ? aview[req.index.num] :
        data_reg[req.index.num];
    wire logic [31:0] index_reg = req.index.long_idx ? idx_raw :
        oad_sext16(idx_raw[WORD_MSB:0]);
    wire logic is_mem = !(req.mode inside {M_DREG, M_AREG, M_IMM, M_IMPLIED});
    wire logic is_step = (req.mode == M_POSTINC) || (req.mode == M_PREDEC);
    wire logic size_reject_now = (req.mode == M_AREG) && (req.size == OAD_SZ_BYTE);
    // Predecrement keeps the address it used; postincrement moves past it
    wire logic [31:0] next_an = (req.mode == M_POSTINC) ? base + step : effective_address;
    wire logic step_en = acc && is_step;
    // A same-cycle write to the stepped register overrides the step
    wire logic conflict = wr_en && wr.is_addr && (wr.num == req.reg_num);

    assign req_ready = ce && (state == ST_IDLE);
    assign wr_reject = wr_en && wr.is_addr && (wr.size == OAD_SZ_BYTE);

    always_comb
    begin
        for (int i = 0; i < NAREG; i++)
            aview[i] = addr_reg[i];
        aview[SP_NUM] = active_sp;
    end

    // Address generation
    always_comb
    begin
        unique case (req.mode)
            M_ABS_W: effective_address = long_disp;
            M_ABS_L: effective_address = req.ext;
            M_PC_D16: effective_address = pc + long_disp;
            M_PC_IDX: effective_address = pc + index_reg + short_disp;
            M_IND, M_POSTINC: effective_address = base;
            M_PREDEC: effective_address = base - step;
            M_D16: effective_address = base + long_disp;
            M_IDX: effective_address = base + index_reg + short_disp;
            default: effective_address = '0;
        endcase
    end

    // Operands that need no memory cycle
    always_comb
    begin
        unique case (req.mode)
            M_DREG: direct = oad_view(data_reg[req.reg_num], req.size);
            M_AREG: direct = oad_view(aview[req.reg_num], req.size);
            M_IMM: direct = (req.size == OAD_SZ_LONG) ? {req.ext.first, req.ext.second} :
                oad_view({{HALF_W{1'b0}}, req.ext.first}, req.size);
            M_IMPLIED:
                unique case (req.implied)
                    IMP_STATUS: direct = {{HALF_W{1'b0}}, status_word};
                    IMP_USP: direct = user_stack_ptr;
                    IMP_SSP: direct = privileged_stack_ptr;
                    IMP_PC: direct = pc;
                endcase
            default: direct = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // Register file writes
    // ----------------------------------------------------------------
    wire logic wr_apply = wr_en && !wr_reject;
    wire logic [31:0] a_write_val = (wr.size == OAD_SZ_WORD) ?
        oad_sext16(wr.data[WORD_MSB:0]) : wr.data;

    // Write port goes last so it wins over a step on the same register
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NREG; i++)
                data_reg[i] <= '0;
            for (int i = 0; i < NAREG; i++)
                addr_reg[i] <= '0;
            user_stack_ptr <= '0;
            privileged_stack_ptr <= '0;
        end
        else if (ce)
        begin
            if (step_en && is_sp && supervisor)
                privileged_stack_ptr <= next_an;
            else if (step_en && is_sp)
                user_stack_ptr <= next_an;
            else if (step_en)
                addr_reg[req.reg_num] <= next_an;
            if (wr_apply && !wr.is_addr)
                data_reg[wr.num] <= oad_merge(data_reg[wr.num], wr.data, wr.size);
            else if (wr_apply && wr.num == SP_NUM && supervisor)
                privileged_stack_ptr <= a_write_val;
            else if (wr_apply && wr.num == SP_NUM)
                user_stack_ptr <= a_write_val;
            else if (wr_apply)
                addr_reg[wr.num] <= a_write_val;
        end
    end

    // ----------------------------------------------------------------
    // Memory sequencer
    // ----------------------------------------------------------------
    oad_word_seq u_seq (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .start(acc && is_mem),
        .start_addr(effective_address),
        .start_size(req.size),
        .start_write(req.write),
        .start_wdata(req.wdata),
        .mem_valid(mem_valid),
        .mem_req(mem_req),
        .mem_ready(mem_ready),
        .mem_rdata(mem_rdata),
        .done(seq_done),
        .fault(seq_fault),
        .rdata(seq_rdata)
    );

    // ----------------------------------------------------------------
    // Result control
    // ----------------------------------------------------------------
    wire logic [31:0] res_src = (state == ST_MEM) ? seq_rdata : direct;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            res_valid <= 1'b0;
            res <= '0;
        end
        else if (ce)
        begin
            res_valid <= 1'b0;
            // Digits follow the source every cycle; they mean something only with res_valid
            res.top_digit <= res_src[BYTE_MSB:NIB_W];
            res.bottom_digit <= res_src[NIB_W - 1:0];
            unique case (state)
                ST_IDLE:
                    if (acc)
                    begin
                        res.ea <= effective_address;
                        res.size_reject <= size_reject_now;
                        res.align_fault <= 1'b0;
                        res.data <= direct;
                        res_valid <= !is_mem;
                        state <= is_mem ? ST_MEM : ST_IDLE;
                    end
                ST_MEM:
                    if (seq_done)
                    begin
                        res.data <= seq_rdata;
                        res.align_fault <= seq_fault;
                        res_valid <= 1'b1;
                        state <= ST_IDLE;
                    end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    postinc_step_a: assert property (acc && req.mode == M_POSTINC
        && !is_sp && !conflict |=> aview[$past(req.reg_num)] == res.ea + $past(step))
        else $error("postincrement did not add the step");
    predec_step_a: assert property (acc && req.mode == M_PREDEC
        && !is_sp && !conflict
        |=> res.ea == $past(base) - $past(step) && aview[$past(req.reg_num)] == res.ea)
        else $error("predecrement address wrong");
    sp_byte_step_a: assert property (acc && req.mode == M_POSTINC && is_sp
        && req.size == OAD_SZ_BYTE && !supervisor && !conflict
        |=> user_stack_ptr == res.ea + STEP_WORD)
        else $error("byte step on stack pointer not two");
    abs_short_a: assert property (acc && req.mode == M_ABS_W
        |=> res.ea == oad_sext16($past(req.ext.first)))
        else $error("absolute short address wrong");
    // Back-to-back direct requests or a frozen cycle keep the pulse up
    direct_result_a: assert property (acc && !is_mem
        |=> res_valid && res.data == $past(direct) ##1 (!res_valid || $past(acc) || !$past(ce)))
        else $error("direct operand result not one cycle later");
    dreg_partial_a: assert property (ce && wr_en && !wr.is_addr
        && wr.size == OAD_SZ_BYTE |=> data_reg[$past(wr.num)][LONG_MSB:BYTE_MSB + 1]
        == $past(data_reg[wr.num][LONG_MSB:BYTE_MSB + 1]))
        else $error("byte write changed upper bits");
    dreg_word_a: assert property (ce && wr_en && !wr.is_addr
        && wr.size == OAD_SZ_WORD |=> data_reg[$past(wr.num)] ==
        {$past(data_reg[wr.num][LONG_MSB:HALF_W]), $past(wr.data[WORD_MSB:0])})
        else $error("word write to data register wrong");
    areg_sext_a: assert property (ce && wr_apply && wr.is_addr && wr.num != SP_NUM
        && wr.size == OAD_SZ_WORD
        |=> addr_reg[$past(wr.num)] == oad_sext16($past(wr.data[WORD_MSB:0])))
        else $error("word write to address register not sign extended");
    areg_byte_a: assert property (wr_en && wr.is_addr && wr.size == OAD_SZ_BYTE
        && wr.num != SP_NUM && !step_en
        |-> wr_reject ##1 addr_reg[$past(wr.num)] == $past(addr_reg[wr.num]))
        else $error("byte write to address register accepted");
    pc_disp_a: assert property (acc && req.mode == M_PC_D16
        |=> res.ea == $past(pc) + oad_sext16($past(req.ext.first)))
        else $error("program counter displacement address wrong");
    pc_index_a: assert property (acc && req.mode == M_PC_IDX
        |=> res.ea == $past(pc) + $past(index_reg) + oad_sext8($past(req.ext.first[BYTE_MSB:0])))
        else $error("program counter index address wrong");
    abs_long_a: assert property (acc && req.mode == M_ABS_L
        |=> res.ea == {$past(req.ext.first), $past(req.ext.second)})
        else $error("absolute long address wrong");
    ce_freeze_a: assert property (!ce |=> $stable(res_valid) && $stable(res) && $stable(state))
        else $error("result moved while clock enable low");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    long_read_c: cover property (acc && is_mem && req.size == OAD_SZ_LONG ##[3:20] res_valid);
    idx_odd_c: cover property (acc && req.mode == M_IDX && effective_address[0]);
    sp_byte_c: cover property (acc && req.mode == M_PREDEC && is_sp && req.size == OAD_SZ_BYTE);
    fault_c: cover property (res_valid && res.align_fault);
    implied_c: cover property (acc && req.mode == M_IMPLIED);

endmodule // oad_datapath

/* File: rtl/oad_pkg.sv */
// Shared types, constants and helpers for the operand addressing datapath.
// Assumes a single core clock; all users import the whole package.
package oad_pkg;

    // ----------------------------------------------------------------
    // Widths and positions
    // ----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int NIB_W = 4;
    localparam int BYTE_MSB = 7;
    localparam int WORD_MSB = 15;
    localparam int LONG_MSB = 31;
    localparam int NREG = 8;
    localparam int NAREG = 7;
    localparam logic [2:0] SP_NUM = 3'h7;

    // ----------------------------------------------------------------
    // Steps, offsets and byte lanes
    // ----------------------------------------------------------------
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;
    localparam logic [31:0] NEXT_WORD_OFS = 32'h0000_0002;
    localparam logic [1:0] LANE_HI = 2'h2;
    localparam logic [1:0] LANE_LO = 2'h1;
    localparam logic [1:0] LANE_BOTH = 2'h3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {OAD_SZ_BYTE, OAD_SZ_WORD, OAD_SZ_LONG} oad_size_t;
    typedef enum logic [3:0] {
        M_DREG, M_AREG, M_ABS_W, M_ABS_L, M_PC_D16, M_PC_IDX, M_IND,
        M_POSTINC, M_PREDEC, M_D16, M_IDX, M_IMM, M_IMPLIED
    } oad_mode_t;
    typedef enum logic [1:0] {IMP_STATUS, IMP_USP, IMP_SSP, IMP_PC} oad_implied_t;

    typedef struct packed {
        logic is_addr;
        logic [2:0] num;
        logic long_idx;
    } oad_index_t;

    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
    } oad_ext_t;

    typedef struct packed {
        oad_mode_t mode;
        oad_size_t size;
        logic [2:0] reg_num;
        oad_index_t index;
        oad_implied_t implied;
        logic write;
        oad_ext_t ext;
        logic [31:0] wdata;
    } oad_req_t;

    typedef struct packed {
        logic is_addr;
        logic [2:0] num;
        oad_size_t size;
        logic [31:0] data;
    } oad_wr_t;

    typedef struct packed {
        logic [31:0] data;
        logic [31:0] ea;
        logic [3:0] top_digit;
        logic [3:0] bottom_digit;
        logic align_fault;
        logic size_reject;
    } oad_res_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [15:0] wdata;
        logic [1:0] lanes;
    } oad_mem_req_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] oad_sext16(input logic [15:0] v);
        return {{HALF_W{v[WORD_MSB]}}, v};
    endfunction

    function automatic logic [31:0] oad_sext8(input logic [7:0] v);
        return {{(DATA_W - BYTE_MSB - 1){v[BYTE_MSB]}}, v};
    endfunction

    // Byte steps on the stack pointer move by a word to keep it even
    function automatic logic [31:0] oad_step(input oad_size_t s, input logic is_sp);
        return (s == OAD_SZ_LONG) ? STEP_LONG :
               (s == OAD_SZ_WORD || is_sp) ? STEP_WORD : STEP_BYTE;
    endfunction

    function automatic logic [31:0] oad_view(input logic [31:0] v, input oad_size_t s);
        return (s == OAD_SZ_LONG) ? v :
               (s == OAD_SZ_WORD) ? {{HALF_W{1'b0}}, v[WORD_MSB:0]} :
               {{(DATA_W - BYTE_MSB - 1){1'b0}}, v[BYTE_MSB:0]};
    endfunction

    function automatic logic [31:0] oad_merge(input logic [31:0] old, input logic [31:0] v,
                                              input oad_size_t s);
        return (s == OAD_SZ_LONG) ? v :
               (s == OAD_SZ_WORD) ? {old[LONG_MSB:HALF_W], v[WORD_MSB:0]} :
               {old[LONG_MSB:BYTE_MSB + 1], v[BYTE_MSB:0]};
    endfunction

endpackage

/* File: rtl/oad_word_seq.sv */
// Memory word sequencer: splits operands into word transfers; only byte transfers may carry an odd address.
// Assumes a 16-bit memory on the core clock with a valid/ready handshake.
`timescale 1ns/1ps
module oad_word_seq
    import oad_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // Operand request
    input wire logic start,
    input wire logic [31:0] start_addr,
    input wire oad_size_t start_size,
    input wire logic start_write,
    input wire logic [31:0] start_wdata,
    // Memory side
    output logic mem_valid,
    output oad_mem_req_t mem_req,
    input wire logic mem_ready,
    input wire logic [15:0] mem_rdata,
    // Completion
    output logic done,
    output logic fault,
    output logic [31:0] rdata
);

    typedef enum logic [1:0] {SQ_IDLE, SQ_HI, SQ_LO} oad_seq_state_t;
    oad_seq_state_t state;
    oad_size_t size;
    logic [15:0] wlo;

    wire logic misaligned = (start_size != OAD_SZ_BYTE) && start_addr[0];
    wire logic is_long = (size == OAD_SZ_LONG);
    wire logic [15:0] byte_rd = mem_req.addr[0] ?
        {{(HALF_W - BYTE_MSB - 1){1'b0}}, mem_rdata[BYTE_MSB:0]} :
        {{(HALF_W - BYTE_MSB - 1){1'b0}}, mem_rdata[WORD_MSB:BYTE_MSB + 1]};
    wire logic [1:0] byte_lane = start_addr[0] ? LANE_LO : LANE_HI;
    wire logic [15:0] first_wd = (start_size == OAD_SZ_LONG) ? start_wdata[LONG_MSB:HALF_W] :
        (start_size == OAD_SZ_WORD) ? start_wdata[WORD_MSB:0] :
        {start_wdata[BYTE_MSB:0], start_wdata[BYTE_MSB:0]};

    assign mem_valid = (state != SQ_IDLE);

    // ----------------------------------------------------------------
    // Transfer sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= SQ_IDLE;
            mem_req <= '0;
            size <= OAD_SZ_BYTE;
            wlo <= '0;
            done <= 1'b0;
            fault <= 1'b0;
            rdata <= '0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            fault <= 1'b0;
            unique case (state)
                SQ_IDLE:
                    if (start && misaligned)
                    begin
                        fault <= 1'b1;
                        done <= 1'b1;
                    end
                    else if (start)
                    begin
                        mem_req.addr <= start_addr;
                        mem_req.write <= start_write;
                        mem_req.wdata <= first_wd;
                        mem_req.lanes <= (start_size == OAD_SZ_BYTE) ? byte_lane : LANE_BOTH;
                        size <= start_size;
                        wlo <= start_wdata[WORD_MSB:0];
                        state <= SQ_HI;
                    end
                SQ_HI:
                    if (mem_ready && is_long)
                    begin
                        rdata[LONG_MSB:HALF_W] <= mem_rdata;
                        mem_req.addr <= mem_req.addr + NEXT_WORD_OFS;
                        mem_req.wdata <= wlo;
                        state <= SQ_LO;
                    end
                    else if (mem_ready)
                    begin
                        rdata <= {{HALF_W{1'b0}}, (size == OAD_SZ_BYTE) ? byte_rd : mem_rdata};
                        done <= 1'b1;
                        state <= SQ_IDLE;
                    end
                SQ_LO:
                    if (mem_ready)
                    begin
                        rdata[WORD_MSB:0] <= mem_rdata;
                        done <= 1'b1;
                        state <= SQ_IDLE;
                    end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    odd_fault_a: assert property (ce && state == SQ_IDLE && start && misaligned
        |=> fault && done && !mem_valid)
        else $error("misaligned access reached memory");
    even_addr_a: assert property (mem_valid && mem_req.lanes == LANE_BOTH
        |-> !mem_req.addr[0])
        else $error("word transfer at odd address");
    second_word_a: assert property (ce && state == SQ_HI && mem_ready && is_long
        |=> state == SQ_LO && mem_req.addr == $past(mem_req.addr) + NEXT_WORD_OFS)
        else $error("second word not at n+2");

endmodule // oad_word_seq

/* File: verif/oad_mem_model.sv */
// Behavioural 16-bit big-endian memory for the operand datapath.
// Assumes valid/ready on the core clock; slow adds wait states.
`timescale 1ns/1ps
module oad_mem_model
    import oad_pkg::*;
(
    // Clock and pace
    input wire logic clock,
    input wire logic [1:0] slow,
    // Memory port
    input wire logic mem_valid,
    input wire oad_mem_req_t mem_req,
    output logic mem_ready,
    output logic [15:0] mem_rdata
);
    logic [7:0] m [256];
    logic [15:0] last = 16'h0000;
    logic [1:0] cnt = 2'h0;
    wire logic [7:0] a = {mem_req.addr[7:1], 1'b0};
    initial
    begin
        mem_ready = 1'b0;
        for (int i = 0; i < 256; i++) m[i] = i[7:0];
    end
    // Outside a handshake the bus shows junk, never the old word
    assign mem_rdata = mem_ready ? {m[a], m[a + 8'h01]} : ~last;
    always @(posedge clock)
    begin
        if (mem_valid && mem_ready)
        begin
            last <= mem_rdata;
            if (mem_req.write && mem_req.lanes[1]) m[a] <= mem_req.wdata[15:8];
            if (mem_req.write && mem_req.lanes[0]) m[a + 8'h01] <= mem_req.wdata[7:0];
            mem_ready <= 1'b0;
            cnt <= 2'h0;
        end
        else if (mem_valid)
        begin
            cnt <= cnt + 2'h1;
            mem_ready <= (cnt >= slow);
        end
    end
endmodule // oad_mem_model

/* File: verif/test_operand_addressing_datapath.sv */
// Self-checking bench for the operand addressing datapath.
// Assumes oad_mem_model on the memory port; inputs move on falling edges.
`timescale 1ns/1ps
module test_operand_addressing_datapath
    import oad_pkg::*;
;
    logic clock = 0, rstn = 0, ce = 1, supervisor = 0, req_valid = 0, wr_en = 0;
    logic [15:0] status_word = 16'h2700;
    logic [31:0] pc = 32'h0000_1000;
    logic [1:0] slow = 2'h0;
    oad_req_t req = '0;
    oad_wr_t wr = '0;
    oad_res_t res, r;
    oad_mem_req_t mem_req;
    logic req_ready, wr_reject, res_valid, mem_valid, mem_ready, got, saw_mem;
    logic [15:0] mem_rdata;
    int miscompares = 0, tests_run = 0;
    oad_datapath dut (.clock(clock), .rstn(rstn), .ce(ce), .supervisor(supervisor),
        .status_word(status_word), .pc(pc), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .wr_en(wr_en), .wr(wr), .wr_reject(wr_reject),
        .res_valid(res_valid), .res(res), .mem_valid(mem_valid), .mem_req(mem_req),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata));
    oad_mem_model mem (.clock(clock), .slow(slow), .mem_valid(mem_valid),
        .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
    initial forever #2.5 clock = ~clock;
    always @(negedge clock) if (res_valid === 1'b1) begin r = res; got = 1; end
    always @(posedge clock) if (mem_valid === 1'b1) saw_mem <= 1;
    task summarize;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end
    endtask
    // Entered at a falling edge; request is idle-accepted at the next edge
    task op(input oad_mode_t m, input oad_size_t s, input logic [2:0] n, input logic [31:0] x);
        int i;
        req.mode = m;
        req.size = s;
        req.reg_num = n;
        req.ext = x;
        got = 0;
        req_valid = 1;
        @(negedge clock);
        req_valid = 0;
        for (i = 0; i < 40 && !got; i++) @(posedge clock);
        @(negedge clock);
        if (!got) begin miscompares++; summarize(); end
    endtask
    task wreg(input logic a, input logic [2:0] n, input oad_size_t s, input logic [31:0] d);
        wr = '{a, n, s, d};
        wr_en = 1;
        #1 chk(wr_reject, a && s == OAD_SZ_BYTE);
        @(negedge clock);
        wr_en = 0;
        @(negedge clock);
    endtask
    task t_regs;
        wreg(0, 3, OAD_SZ_LONG, 32'h1122_3344);
        wreg(0, 3, OAD_SZ_WORD, 32'hBBBB_6789);
        op(M_DREG, OAD_SZ_LONG, 3, 0); chk(r.data, 32'h1122_6789);
        op(M_DREG, OAD_SZ_BYTE, 3, 0); chk(r.data, 32'h0000_0089);
        chk({24'h0, r.top_digit, r.bottom_digit}, 32'h0000_0089);
        wreg(1, 2, OAD_SZ_WORD, 32'h0000_8000);
        wreg(1, 2, OAD_SZ_BYTE, 32'h0000_0011);
        op(M_AREG, OAD_SZ_LONG, 2, 0); chk(r.data, 32'hFFFF_8000);
        op(M_AREG, OAD_SZ_BYTE, 2, 0); chk(r.size_reject, 1);
    endtask
    task t_step;
        wreg(1, 1, OAD_SZ_LONG, 32'h0000_0040);
        op(M_POSTINC, OAD_SZ_WORD, 1, 0); chk(r.ea, 32'h0000_0040);
        chk(r.data, 32'h0000_4041);
        slow = 2'h2;
        op(M_PREDEC, OAD_SZ_LONG, 1, 0); chk(r.ea, 32'h0000_003E);
        chk(r.data, 32'h3E3F_4041);
        slow = 2'h0;
        wreg(1, 7, OAD_SZ_LONG, 32'h0000_0080);
        op(M_POSTINC, OAD_SZ_BYTE, 7, 0); chk(r.data, 32'h0000_0080);
        op(M_AREG, OAD_SZ_LONG, 7, 0); chk(r.data, 32'h0000_0082);
        supervisor = 1;
        op(M_AREG, OAD_SZ_LONG, 7, 0); chk(r.data, 32'h0000_0000);
        supervisor = 0;
    endtask
    task t_mem;
        wreg(1, 4, OAD_SZ_LONG, 32'h0000_0051);
        saw_mem = 0;
        op(M_IND, OAD_SZ_WORD, 4, 0); chk(r.align_fault, 1);
        chk(saw_mem, 0);
        wreg(1, 5, OAD_SZ_LONG, 32'h0000_0060);
        req.write = 1;
        req.wdata = 32'hCAFE_F00D;
        op(M_IND, OAD_SZ_LONG, 5, 0);
        req.write = 0;
        op(M_IND, OAD_SZ_LONG, 5, 0); chk(r.data, 32'hCAFE_F00D);
        op(M_PC_D16, OAD_SZ_WORD, 0, 32'hFFF0_0000); chk(r.ea, 32'h0000_0FF0);
        req.index = '{1'b1, 3'h2, 1'b0};
        op(M_PC_IDX, OAD_SZ_WORD, 0, 32'h0004_0000); chk(r.ea, 32'hFFFF_9004);
        op(M_IDX, OAD_SZ_BYTE, 5, 32'h0001_0000); chk(r.ea, 32'hFFFF_8061);
        chk(r.data, 32'h0000_00FE);
        op(M_D16, OAD_SZ_WORD, 5, 32'hFFFE_0000); chk(r.data, 32'h0000_5E5F);
        op(M_ABS_W, OAD_SZ_WORD, 0, 32'h8000_0000); chk(r.ea, 32'hFFFF_8000);
        op(M_ABS_L, OAD_SZ_LONG, 0, 32'h0000_0020); chk(r.data, 32'h2021_2223);
        op(M_IMM, OAD_SZ_WORD, 0, 32'h1234_0000); chk(r.data, 32'h0000_1234);
        op(M_IMM, OAD_SZ_LONG, 0, 32'h1234_5678); chk(r.data, 32'h1234_5678);
        req.implied = IMP_STATUS;
        op(M_IMPLIED, OAD_SZ_WORD, 0, 0); chk(r.data, 32'h0000_2700);
        req.implied = IMP_PC;
        op(M_IMPLIED, OAD_SZ_LONG, 0, 0); chk(r.data, 32'h0000_1000);
        req.implied = IMP_USP;
        op(M_IMPLIED, OAD_SZ_LONG, 0, 0); chk(r.data, 32'h0000_0082);
        ce = 0;
        @(negedge clock);
        chk(req_ready, 0);
        ce = 1;
    endtask
    initial
    begin
        repeat (12) @(negedge clock);
        rstn = 1;
        @(negedge clock);
        t_regs();
        t_step();
        t_mem();
        summarize();
    end
endmodule // test_operand_addressing_datapath
